// ===== secl_pkg.sv
//////////////////////////////////////////////////////////////////////////////
// constants and types for the serial config loader
// assumes a 100 MHz core clock and a three-wire read-only config rom
//////////////////////////////////////////////////////////////////////////////
package secl_pkg;
   // core clock period
   localparam int unsigned CLK_PERIOD_NS    = 10;
   // serial clock full periods per on-chip bus clock setting
   localparam int unsigned SK_PERIOD_00_NS  = 800;
   localparam int unsigned SK_PERIOD_01_NS  = 1600;
   localparam int unsigned SK_PERIOD_10_NS  = 3200;
   localparam int unsigned SK_PERIOD_11_NS  = 4000;
   // half periods in core cycles (exact for 10 ns, rounded down otherwise)
   localparam logic [8:0]  HALF_00 = 9'(SK_PERIOD_00_NS / CLK_PERIOD_NS / 2);
   localparam logic [8:0]  HALF_01 = 9'(SK_PERIOD_01_NS / CLK_PERIOD_NS / 2);
   localparam logic [8:0]  HALF_10 = 9'(SK_PERIOD_10_NS / CLK_PERIOD_NS / 2);
   localparam logic [8:0]  HALF_11 = 9'(SK_PERIOD_11_NS / CLK_PERIOD_NS / 2);
   // on-chip bus clock select encodings
   localparam logic [1:0]  BUS_SEL_125 = 2'h0;
   localparam logic [1:0]  BUS_SEL_01  = 2'h1;
   localparam logic [1:0]  BUS_SEL_10  = 2'h2;
   localparam logic [1:0]  BUS_SEL_25  = 2'h3;
   // rom frame layout: start bit, read opcode, address, dummy, data
   localparam int unsigned ADDR_W      = 6;
   localparam int unsigned WORD_W      = 16;
   localparam logic [2:0]  READ_CMD    = 3'h6;
   localparam int unsigned CMD_W       = 3 + ADDR_W;
   localparam logic [4:0]  TOT_BITS    = 5'(CMD_W + 1 + WORD_W);
   localparam logic [4:0]  DATA_FIRST  = 5'(CMD_W + 1);
   // cycles spent letting the strap synchronisers settle after reset
   localparam logic [2:0]  SETTLE_LAST = 3'h4;

   // loader states, one-hot
   typedef enum logic [3:0] {
      ST_SETTLE = 4'h1,
      ST_SHIFT  = 4'h2,
      ST_GAP    = 4'h4,
      ST_DONE   = 4'h8
   } secl_state_t;

   // one loaded configuration word and where it came from
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [WORD_W-1:0] data;
   } secl_word_t;
endpackage

// ===== secl_loader.sv
//////////////////////////////////////////////////////////////////////////////
// serial config rom loader: reads config words at reset, or takes the
// bus-width strap when no rom is fitted
// assumes straps and rom data arrive asynchronously; select is core-timed
//////////////////////////////////////////////////////////////////////////////
// Function
// - strap high: rom present, load from it
// - strap low: no rom, no serial load
// - select 11: serial clock period 4 us
// - select 00: serial clock period 800 ns
// - commands, addresses shifted out serially
// - sample config bits from rom data pin
// - no rom: data pin is bus-width strap
module secl_loader
   import secl_pkg::*;
#(
   parameter int unsigned NUM_WORDS = 8
) (
   input  wire logic       clk_i,
   input  wire logic       reset_n_i,
   input  wire logic       rom_present_strap_i,
   input  wire logic       rom_serial_in_i,
   input  wire logic [1:0] onchip_bus_clock_select_i,
   output logic            rom_select_o,
   output logic            rom_serial_clock_o,
   output logic            rom_serial_out_o,
   output secl_word_t      cfg_o,
   output logic            cfg_valid_o,
   output logic            load_done_o,
   output logic            rom_used_o,
   output logic            bus_width16_o
);

   // elaboration check: the address field must hold every word index
   if (NUM_WORDS < 1 || NUM_WORDS > (1 << ADDR_W)) begin : g_bad_words
      $error("secl_loader: NUM_WORDS out of range");
   end

   //////////////////////////////////////////////////////////////////////////
   // declarations
   logic [1:0]        en_s_q;      // strap synchroniser
   logic [1:0]        di_s_q;      // rom data synchroniser
   secl_state_t       st_q;        // loader state
   logic [2:0]        settle_q;    // settle counter
   logic [8:0]        div_q;       // half-period divider
   logic [4:0]        bit_q;       // rising edges seen in this frame
   logic [CMD_W-2:0]  cmd_q;       // command bits still to send
   logic [WORD_W-1:0] data_q;      // incoming data shifter
   logic [ADDR_W-1:0] addr_q;      // word being read
   logic              cs_q;        // rom select
   logic              sk_q;        // serial clock
   logic              out_q;       // serial data to rom
   secl_word_t        cfg_q;       // last word
   logic              valid_q;     // word pulse
   logic              done_q;      // load finished
   logic              used_q;      // rom found
   logic              w16_q;       // bus width strap

   //////////////////////////////////////////////////////////////////////////
   // decode
   logic [8:0] half_lim;   // half period for current bus clock
   logic       tick;       // divider terminal count
   logic       sk_rise;    // serial clock about to rise
   logic       sk_fall;    // serial clock about to fall
   logic       settled;    // synchronisers hold clean straps
   logic       frame_end;  // last falling edge of a frame
   logic       last_word;  // final address reached
   logic       in_data;    // rising edge carries a data bit

   assign half_lim  = (onchip_bus_clock_select_i == BUS_SEL_25)  ? HALF_11 :
                      (onchip_bus_clock_select_i == BUS_SEL_10)  ? HALF_10 :
                      (onchip_bus_clock_select_i == BUS_SEL_01)  ? HALF_01 :
                                                                   HALF_00;
   assign tick      = (div_q >= half_lim - 9'h001);
   assign sk_rise   = (st_q == ST_SHIFT) && tick && !sk_q;
   assign sk_fall   = (st_q == ST_SHIFT) && tick && sk_q;
   assign settled   = (st_q == ST_SETTLE) && (settle_q == SETTLE_LAST);
   assign frame_end = sk_fall && (bit_q == TOT_BITS);
   assign last_word = (addr_q == ADDR_W'(NUM_WORDS - 1));
   assign in_data   = sk_rise && (bit_q >= DATA_FIRST);

   //////////////////////////////////////////////////////////////////////////
   // two-flop synchronisers; only the second stage is read
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         en_s_q <= 2'h0;
         di_s_q <= 2'h0;
      end else begin
         en_s_q <= {en_s_q[0], rom_present_strap_i};
         di_s_q <= {di_s_q[0], rom_serial_in_i};
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // state sequencing
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         st_q <= ST_SETTLE;
      end else begin
         case (st_q)
            ST_SETTLE: begin
               if (settled) begin
                  st_q <= en_s_q[1] ? ST_SHIFT : ST_DONE;
               end
            end
            ST_SHIFT: begin
               if (frame_end) begin
                  st_q <= ST_GAP;
               end
            end
            ST_GAP: begin
               // gap of one half period with select low between words
               if (tick) begin
                  st_q <= last_word ? ST_DONE : ST_SHIFT;
               end
            end
            ST_DONE:  st_q <= ST_DONE;
            default:  st_q <= ST_SETTLE;
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // settle counter and divider
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         settle_q <= 3'h0;
         div_q    <= 9'h000;
      end else begin
         settle_q <= settled ? settle_q : settle_q + 3'h1;
         // divider restarts each half period; idles outside shift and gap
         div_q    <= (tick || st_q == ST_SETTLE || st_q == ST_DONE) ? 9'h000
                     : div_q + 9'h001;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // serial link: select, clock, command out
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         cs_q  <= 1'b0;
         sk_q  <= 1'b0;
         out_q <= 1'b0;
         cmd_q <= '0;
         bit_q <= 5'h00;
      end else if ((settled && en_s_q[1]) || (st_q == ST_GAP && tick && !last_word)) begin
         // select raised for a new read
         cs_q  <= 1'b1;
         out_q <= READ_CMD[2];
         cmd_q <= {READ_CMD[1:0], settled ? ADDR_W'(0) : addr_q + ADDR_W'(1)};
         bit_q <= 5'h00;
      end else if (frame_end) begin
         cs_q  <= 1'b0;
         sk_q  <= 1'b0;
         out_q <= 1'b0;
      end else if (sk_fall) begin
         sk_q  <= 1'b0;
         out_q <= cmd_q[CMD_W-2];
         cmd_q <= {cmd_q[CMD_W-3:0], 1'b0};
      end else if (sk_rise) begin
         sk_q  <= 1'b1;
         bit_q <= bit_q + 5'h01;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // data capture and results
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         data_q  <= '0;
         addr_q  <= '0;
         cfg_q   <= '0;
         valid_q <= 1'b0;
      end else begin
         // sample rom data on rising edge
         if (in_data) begin
            data_q <= {data_q[WORD_W-2:0], di_s_q[1]};
         end
         if (st_q == ST_GAP && tick && !last_word) begin
            addr_q <= addr_q + ADDR_W'(1);
         end
         valid_q <= frame_end;
         if (frame_end) begin
            cfg_q <= '{addr: addr_q, data: data_q};
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // path flags; strap value taken once, after release, through the sync
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         used_q <= 1'b0;
         w16_q  <= 1'b0;
         done_q <= 1'b0;
      end else begin
         if (settled) begin
            used_q <= en_s_q[1];
            // data pin read as width strap
            w16_q  <= en_s_q[1] ? 1'b0 : di_s_q[1];
         end
         done_q <= (settled && !en_s_q[1]) || (st_q == ST_GAP && tick && last_word)
                   || done_q;
      end
   end

   assign rom_select_o       = cs_q;
   assign rom_serial_clock_o = sk_q;
   assign rom_serial_out_o   = out_q;
   assign cfg_o              = cfg_q;
   assign cfg_valid_o        = valid_q;
   assign load_done_o        = done_q;
   assign rom_used_o         = used_q;
   assign bus_width16_o      = w16_q;

   //////////////////////////////////////////////////////////////////////////
   // assertions

   // helper: cycles the select has stood high, against a whole frame
   logic [15:0] cs_len_q;   // select high time so far
   logic [15:0] frame_len;  // two half periods per serial clock rise
   assign frame_len = 16'(half_lim) * 16'({TOT_BITS, 1'b0});
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         cs_len_q <= 16'h0000;
      end else begin
         cs_len_q <= cs_q ? cs_len_q + 16'h0001 : 16'h0000;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);

   strap_high_load_a: assert property (
      settled && en_s_q[1] |=> cs_q && used_q && !done_q)
      else $error("rom strap high but load not started");
   strap_low_quiet_a: assert property (
      !used_q && (st_q != ST_SETTLE) |-> !cs_q && !sk_q && !valid_q)
      else $error("serial activity with rom absent");
   period_slow_a: assert property (
      $rose(sk_q) && onchip_bus_clock_select_i == BUS_SEL_25 |-> ##199 sk_q ##1 !sk_q)
      else $error("serial clock high time wrong at slow bus");
   period_fast_a: assert property (
      $rose(sk_q) && onchip_bus_clock_select_i == BUS_SEL_125 |-> ##39 sk_q ##1 !sk_q)
      else $error("serial clock high time wrong at fast bus");
   out_on_fall_a: assert property (
      $changed(out_q) |-> $fell(sk_q) || $rose(cs_q) || $fell(cs_q))
      else $error("serial out moved while clock high");
   word_from_rom_a: assert property (
      valid_q |-> used_q && !cs_q && $past(cs_q))
      else $error("word presented without rom frame");
   width_strap_a: assert property (
      $rose(done_q) && !used_q |-> w16_q == $past(di_s_q[1]))
      else $error("bus width strap not captured");
   select_frame_a: assert property (
      $fell(cs_q) |-> cs_len_q == frame_len)
      else $error("select not held for a whole frame");

   cover_rom_load_c:  cover property (used_q && $rose(done_q));
   cover_strap_16_c:  cover property (!used_q && $rose(done_q) && w16_q);
   cover_word_c:      cover property (valid_q && cfg_q.data != '0);
   cover_slow_clk_c:  cover property ($rose(sk_q) && onchip_bus_clock_select_i == BUS_SEL_25);
endmodule

// ===== secl_rom_model.sv
//////////////////////////////////////////////////////////////////////////////
// behavioural three-wire config rom, far side of the loader's serial pins
// assumes the bench preloads mem and that the loader owns select and clock
//////////////////////////////////////////////////////////////////////////////
module secl_rom_model (
   input  wire logic clk_i,
   input  wire logic sel_i,
   input  wire logic sck_i,
   input  wire logic din_i,
   input  wire logic slow_i,
   output logic      dout_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] mem [64];   // word store, filled by the bench
   logic [8:0]  cmd;        // start, opcode, address
   int          rises;      // serial clock rises in this frame
   int          bad_cmds;   // frames with a wrong start or opcode
   int          bad_frames; // frames not 26 clocks long
   logic        framing;    // a select rise has opened a frame
   initial begin
      framing = 1'b0;
      dout_o = 1'b0;
      cmd = 9'h000;
      rises = 0;
      bad_cmds = 0;
      bad_frames = 0;
   end
   // fresh frame on every select rise
   always @(posedge sel_i) begin
      rises = 0;
      framing = 1'b1;
   end
   // whole frame per select; the power-up fall opens no frame
   always @(negedge sel_i) if (framing) begin
      if (rises != 26) bad_frames++;
      framing = 1'b0;
   end
   always @(posedge sck_i) if (sel_i) begin
      rises++;
      if (rises <= 9) cmd = {cmd[7:0], din_i};
      if (rises == 9 && cmd[8:6] != 3'h6) bad_cmds++;
   end
   // dummy zero then data msb first, slow mode answers late
   always @(negedge sck_i) if (sel_i && rises >= 9 && rises < 26) begin
      #(slow_i ? 150 : 1);
      dout_o = (rises == 9) ? 1'b0 : mem[cmd[5:0]][25 - rises];
   end
   // released pin: rom output floats, the pad pull-down takes it low
   always @(posedge clk_i) if (!sel_i) dout_o <= 1'b0;
endmodule

// ===== secl_loader_tb.sv
//////////////////////////////////////////////////////////////////////////////
// self-checking bench for the config loader with a behavioural rom
// assumes 100 MHz core clock; inputs change on the falling edge
//////////////////////////////////////////////////////////////////////////////
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
   $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module secl_loader_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import secl_pkg::*;
   logic        clk = 1'b0;      // core clock
   logic        reset_n = 1'b0;  // active low reset
   logic        strap = 1'b0;    // rom present strap
   logic        strap_w16 = 1'b0; // data pin level when no rom
   logic        slow = 1'b0;     // rom answers late
   logic [1:0]  sel_r = 2'h0;    // bus clock select
   logic        rom_do;          // rom data out
   logic        cs, sk, dout, valid, done, used, w16;
   secl_word_t  cfg;
   secl_word_t  expq [$];        // expected words in order
   secl_word_t  exp_w;
   int          errors = 0;
   int          checked = 0;
   int          rise_n;          // sk rises this run
   time         t1, t2;          // first two sk rises
   logic [31:0] lfsr_q = 32'h762B6207;
   int          per [4] = '{800, 1600, 3200, 4000};
   always #5 clk = ~clk;
   // pin is the rom when fitted, a strap otherwise
   wire rom_in = strap ? rom_do : strap_w16;
   secl_loader #(.NUM_WORDS(2)) u_secl_loader (
      .clk_i(clk), .reset_n_i(reset_n), .rom_present_strap_i(strap),
      .rom_serial_in_i(rom_in), .onchip_bus_clock_select_i(sel_r),
      .rom_select_o(cs), .rom_serial_clock_o(sk), .rom_serial_out_o(dout),
      .cfg_o(cfg), .cfg_valid_o(valid), .load_done_o(done), .rom_used_o(used),
      .bus_width16_o(w16));
   secl_rom_model u_secl_rom_model (.clk_i(clk), .sel_i(cs), .sck_i(sk),
      .din_i(dout), .slow_i(slow), .dout_o(rom_do));
   function automatic logic [15:0] rnd();
      lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
      return lfsr_q[15:0];
   endfunction
   // serial clock period watch
   always @(posedge sk) begin
      rise_n++;
      if (rise_n == 1) t1 = $time;
      if (rise_n == 2) t2 = $time;
   end
   // every loaded word against the queue, in address order; looked at
   // on the falling edge, where the one-cycle valid pulse has settled
   always @(negedge clk) if (reset_n && valid === 1'b1) begin
      if (expq.size() == 0) begin
         errors++;
         $display("[FAIL] %0t got %h exp %h", $time, cfg, 22'h0);
      end else begin
         exp_w = expq.pop_front();
         `CHK(cfg, exp_w)
      end
   end
   task automatic run(input logic pres, input logic [1:0] s, input logic wide);
      int n;
      reset_n = 1'b0;
      strap = pres;
      sel_r = s;
      strap_w16 = wide;
      slow = s[0];
      expq.delete();
      for (int i = 0; i < 2; i++) begin
         u_secl_rom_model.mem[i] = rnd();
         if (pres) expq.push_back('{addr: 6'(i), data: u_secl_rom_model.mem[i]});
      end
      repeat (16) @(negedge clk);
      rise_n = 0;
      reset_n = 1'b1;
      n = 0;
      while (done !== 1'b1 && n < 60000) begin
         @(negedge clk);
         n++;
      end
      repeat (4) @(negedge clk);
      `CHK(done, 1'b1)
      `CHK(used, pres)
      `CHK(w16, pres ? 1'b0 : wide)
      `CHK(rise_n, pres ? 52 : 0)
      `CHK(expq.size(), 0)
      `CHK(u_secl_rom_model.bad_cmds, 0)
      `CHK(u_secl_rom_model.bad_frames, 0)
      if (pres) `CHK(64'(t2 - t1), 64'(per[s]))
      else `CHK(n <= 8, 1'b1)
      $display("test pres=%0d sel=%0d wide=%0d ended", pres, s, wide);
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // main sequence: all four selects with a rom, then both straps without
   initial begin
      for (int s = 0; s < 4; s++) run(1'b1, 2'(s), 1'b0);
      run(1'b0, 2'h0, 1'b0);
      run(1'b0, 2'h3, 1'b1);
      results();
   end
   // hang guard, well past the ~510 us the runs need, under 100k cycles
   initial begin
      #900000;
      errors++;
      results();
   end
endmodule
